// [logic/fdp_transfer.sv]
// floppy dma transfer path: request/hold/ack handshake, drive select,
// sector id handling, window recentring and motor-stop timer
// assumes a synchronous system with external cpu, memory and drives
// Notes on behaviour
// RULE1 - one request per byte goes to both dma and separator.
// RULE2 - a pending request makes the dma side raise bus hold request.
// RULE3 - the cpu side releases the bus and then returns hold acknowledge.
// RULE4 - after hold acknowledge the dma side asserts transfer acknowledge.
// RULE5 - while holding the bus the dma side moves each byte without the cpu.
// RULE6 - low format: tracks 0-39, sectors 1-16, whole 256-byte sectors.
// RULE7 - high format uses tracks 0 to 79, sectors 1 to 16 per side.
// RULE8 - on the high interface a low format disk may only be read.
// RULE9 - any one of four drives may be selected.
// RULE10 - high variant: selects 0-2 from controller, 3 from sound port bit.
// RULE11 - the separator splits read pulses and recentres data in its window.
// RULE12 - a separator timer produces the spindle motor stop signal.
// RULE13 - sector id: track, side, sector; set by format, matched on access.
// RULE14 - at most one drive select line is active at a time.
`timescale 1ns/1ps
`include "fdp_defines.svh"
module fdp_transfer
  import fdp_pkg::*;
#(
  parameter int MOTOR_CYC = (`FDP_MOTOR_MS * `FDP_CLK_MHZ * 32'd1000)
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic start,
  input wire fdp_op_t op,
  input wire fdp_chs_t target,
  input wire logic [1:0] drive_num,
  input wire logic hi_iface,
  input wire logic disk_hi_fmt,
  input wire logic sound_port_bit,
  input wire logic bus_hold_ack,
  input wire logic [7:0] mem_rdata,
  input wire logic read_stream,
  input wire logic id_valid,
  input wire fdp_chs_t id_seen,
  input wire logic [7:0] disk_rdata,
  output logic bus_hold_request,
  output logic xfer_request,
  output logic xfer_ack,
  output fdp_mem_t mem_bus,
  output logic [7:0] disk_wdata,
  output logic disk_wstrobe,
  output logic id_write,
  output logic [2:0] drive_select_low,
  output logic drive_select_fourth,
  output logic motor_stop,
  output logic sep_clock_pulse,
  output logic sep_data_pulse,
  output logic busy,
  output logic refused
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // both arrive from outside this clock, so two flops before any use
  logic hold_ack_s1_ff, hold_ack_s2_ff, rs_s1_ff, rs_s2_ff, rs_d_ff;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hold_ack_s1_ff <= 1'b0;
      hold_ack_s2_ff <= 1'b0;
      rs_s1_ff <= 1'b0;
      rs_s2_ff <= 1'b0;
      rs_d_ff <= 1'b0;
    end else begin
      hold_ack_s1_ff <= bus_hold_ack;
      hold_ack_s2_ff <= hold_ack_s1_ff;
      rs_s1_ff <= read_stream;
      rs_s2_ff <= rs_s1_ff;
      rs_d_ff <= rs_s2_ff;
    end
  end
  wire rs_rise = rs_s2_ff & ~rs_d_ff;

  // ------------------------------------------------------------
  // command check and sector id match
  // ------------------------------------------------------------
  logic [6:0] last_trk;
  logic cmd_ok;
  // RULE6 RULE7 address range per format
  assign last_trk = disk_hi_fmt ? `FDP_HI_LAST_TRACK : `FDP_LO_LAST_TRACK;
  always_comb begin
    cmd_ok = (target.track <= last_trk) &&
             (target.sector >= `FDP_FIRST_SECTOR) &&
             (target.sector <= `FDP_LAST_SECTOR);
    // RULE8 low format on high interface is read only
    if (hi_iface && !disk_hi_fmt && op != FDP_OP_READ) begin
      cmd_ok = 1'b0;
    end
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_SEEK, ST_REQ, ST_HOLD, ST_MOVE, ST_DONE
  } fdp_state_t;
  fdp_state_t state_ff;
  fdp_op_t op_ff;
  fdp_chs_t chs_ff;
  logic [8:0] cnt_ff;
  logic id_match;
  // RULE13 sector located by id field match
  assign id_match = id_valid && (id_seen == chs_ff);

  // ------------------------------------------------------------
  // transfer sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      op_ff <= FDP_OP_READ;
      chs_ff <= '0;
      cnt_ff <= 9'h000;
      refused <= 1'b0;
    end else begin
      refused <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (start && cmd_ok) begin
            state_ff <= (op == FDP_OP_FORMAT) ? ST_REQ : ST_SEEK;
            op_ff <= op;
            chs_ff <= target;
            cnt_ff <= 9'h000;
          end else if (start) begin
            refused <= 1'b1;
          end
        end
        ST_SEEK: begin
          if (id_match) begin
            state_ff <= ST_REQ;
          end
        end
        // RULE2 request leads to hold request
        ST_REQ: state_ff <= ST_HOLD;
        ST_HOLD: begin
          // RULE3 wait for the cpu side to grant the bus
          if (hold_ack_s2_ff) begin
            state_ff <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          // RULE6 whole sectors of 256 bytes
          if (cnt_ff == `FDP_SECTOR_BYTES - 9'h001) begin
            state_ff <= ST_DONE;
          end else begin
            cnt_ff <= cnt_ff + 9'h001;
            state_ff <= ST_REQ;
          end
        end
        ST_DONE: begin
          if (!hold_ack_s2_ff) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // RULE1 one request per byte, shared with the separator
  assign xfer_request = (state_ff == ST_REQ) || (state_ff == ST_HOLD);
  // RULE2 hold request while a byte waits or moves
  assign bus_hold_request = xfer_request || (state_ff == ST_MOVE);
  // RULE4 ack only once hold acknowledge is seen
  assign xfer_ack = (state_ff == ST_MOVE);
  assign busy = (state_ff != ST_IDLE);
  // RULE13 id field written only when formatting
  assign id_write = (state_ff == ST_MOVE) && (op_ff == FDP_OP_FORMAT);

  // ------------------------------------------------------------
  // byte move on the system bus
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mem_bus <= '0;
      disk_wdata <= 8'h00;
      disk_wstrobe <= 1'b0;
    end else begin
      // RULE5 dma moves the byte without the cpu
      mem_bus.mem_wr <= (state_ff == ST_MOVE) && (op_ff == FDP_OP_READ);
      mem_bus.mem_rd <= (state_ff == ST_HOLD) && hold_ack_s2_ff &&
                        (op_ff != FDP_OP_READ);
      disk_wstrobe <= (state_ff == ST_MOVE) && (op_ff != FDP_OP_READ);
      if (state_ff == ST_MOVE) begin
        mem_bus.data <= disk_rdata;
        disk_wdata <= mem_rdata;
      end
    end
  end

  // ------------------------------------------------------------
  // drive select
  // ------------------------------------------------------------
  logic [1:0] drv_ff;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      drv_ff <= 2'h0;
    end else if (state_ff == ST_IDLE && start) begin
      // RULE9 any of four drives
      drv_ff <= drive_num;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      drive_select_low <= 3'h0;
      drive_select_fourth <= 1'b0;
    end else begin
      // RULE14 one-hot select, at most one line
      drive_select_low <= (busy && drv_ff != 2'h3) ?
                          3'(3'h1 << drv_ff) : 3'h0;
      // RULE10 fourth line gated by the sound generator port bit on the high interface only
      drive_select_fourth <= busy && drv_ff == 2'h3 &&
                             (hi_iface ? sound_port_bit : 1'b1);
    end
  end

  // ------------------------------------------------------------
  // data separator: window recentring
  // ------------------------------------------------------------
  logic [7:0] win_ff;
  logic slot_ff, pend_ff;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      win_ff <= 8'h00;
      slot_ff <= 1'b0;
      pend_ff <= 1'b0;
      sep_clock_pulse <= 1'b0;
      sep_data_pulse <= 1'b0;
    end else begin
      sep_clock_pulse <= 1'b0;
      sep_data_pulse <= 1'b0;
      // RULE11 alternate clock and data windows
      if (win_ff == `FDP_WIN_CYC - 8'h01) begin
        win_ff <= 8'h00;
        slot_ff <= ~slot_ff;
      end else begin
        win_ff <= win_ff + 8'h01;
      end
      if (rs_rise && !slot_ff) begin
        sep_clock_pulse <= 1'b1;
      end
      if (rs_rise && slot_ff) begin
        pend_ff <= 1'b1;
      end
      // RULE11 data released at window centre
      if (slot_ff && win_ff == `FDP_WIN_MID && (pend_ff || rs_rise)) begin
        sep_data_pulse <= 1'b1;
        pend_ff <= 1'b0;
      end else if (!slot_ff) begin
        pend_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // motor stop timer
  // ------------------------------------------------------------
  logic [31:0] idle_ff;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      idle_ff <= 32'h0;
      motor_stop <= 1'b1;
    end else if (xfer_request || busy) begin
      idle_ff <= 32'h0;
      motor_stop <= 1'b0;
    end else if (idle_ff >= 32'(MOTOR_CYC) - 32'h1) begin
      // RULE12 timer stops the spindle
      motor_stop <= 1'b1;
    end else begin
      idle_ff <= idle_ff + 32'h1;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_ack_after_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(xfer_ack) |-> $past(hold_ack_s2_ff)) // RULE4
    else $error("ack without hold acknowledge");
  chk_hold_follows_req: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    xfer_request |-> bus_hold_request) // RULE2
    else $error("request without hold request");
  chk_req_one_byte: assert property (@(posedge clk_sys) disable iff (!resetn)
    xfer_ack |=> !xfer_ack) // RULE1
    else $error("ack longer than one byte");
  chk_one_select: assert property (@(posedge clk_sys) disable iff (!resetn)
    $onehot0({drive_select_low, drive_select_fourth})) // RULE14
    else $error("more than one drive selected");
  chk_low_fmt_ro: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_ff == ST_IDLE && start && hi_iface && !disk_hi_fmt &&
     op != FDP_OP_READ) |=> refused) // RULE8
    else $error("write to low format accepted");
  chk_id_write_fmt: assert property (@(posedge clk_sys) disable iff (!resetn)
    id_write |-> op_ff == FDP_OP_FORMAT) // RULE13
    else $error("id written outside format");
  chk_move_on_bus: assert property (@(posedge clk_sys) disable iff (!resetn)
    (xfer_ack && op_ff == FDP_OP_READ) |=> mem_bus.mem_wr) // RULE5
    else $error("byte not moved to memory");
  chk_motor_runs: assert property (@(posedge clk_sys) disable iff (!resetn)
    busy |=> !motor_stop) // RULE12
    else $error("motor stopped while busy");
endmodule : fdp_transfer

// [inc/fdp_defines.svh]
// constants for the floppy dma transfer path
// assumes inclusion from the package and the design module only
`ifndef FDP_DEFINES_SVH
`define FDP_DEFINES_SVH
`define FDP_LO_LAST_TRACK 7'h27
`define FDP_HI_LAST_TRACK 7'h4f
`define FDP_FIRST_SECTOR 5'h01
`define FDP_LAST_SECTOR 5'h10
`define FDP_SECTOR_BYTES 9'h100
`define FDP_MOTOR_MS 32'd2000
`define FDP_CLK_MHZ 32'd100
`define FDP_WIN_CYC 8'h28
`define FDP_WIN_MID 8'h14
`endif

// [inc/fdp_pkg.sv]
// types for the floppy dma transfer path
// assumes fdp_defines.svh sits in the include path
package fdp_pkg;
  `include "fdp_defines.svh"
  typedef enum logic [1:0] {
    FDP_OP_READ,
    FDP_OP_WRITE,
    FDP_OP_FORMAT
  } fdp_op_t;
  typedef struct packed {
    logic [6:0] track;
    logic side;
    logic [4:0] sector;
  } fdp_chs_t;
  typedef struct packed {
    logic mem_rd;
    logic mem_wr;
    logic [7:0] data;
  } fdp_mem_t;
endpackage : fdp_pkg

// [sim/fdp_cpu_model.sv]
// cpu side bus owner model for the floppy dma transfer path
// assumes hold request from the design and a wait count from the bench
`timescale 1ns/1ps
module fdp_cpu_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic bus_hold_request,
  input wire logic [3:0] dly,
  output logic bus_hold_ack
);
  logic [3:0] cnt_ff;
  // release then ack
  // the wait stands for a cpu bus cycle that must finish first
  always_ff @(posedge clk_sys) begin
    if (!resetn || !bus_hold_request) begin
      cnt_ff <= 4'h0;
      bus_hold_ack <= 1'b0;
    end else if (cnt_ff >= dly) begin
      bus_hold_ack <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
endmodule : fdp_cpu_model

// [sim/fdp_transfer_tb.sv]
// bench for the floppy dma transfer path
// assumes the cpu model as bus owner and the bench as disk and memory
`timescale 1ns/1ps
module fdp_transfer_tb
  import fdp_pkg::*;
;
  logic clk_sys = 0, resetn = 0, start = 0, hi_iface = 0;
  logic disk_hi_fmt = 0, sound_port_bit = 1, read_stream = 0;
  logic id_valid = 0;
  fdp_op_t op = FDP_OP_READ;
  fdp_chs_t target = '0, id_seen = '0;
  logic [1:0] drive_num = 2'h0;
  logic [7:0] mem_rdata = 8'h00, disk_rdata = 8'h00, e;
  logic [3:0] dly = 4'h0;
  logic bus_hold_ack, bus_hold_request, xfer_request, xfer_ack;
  logic disk_wstrobe, id_write, drive_select_fourth, motor_stop;
  logic sep_clock_pulse, sep_data_pulse, busy, refused;
  fdp_mem_t mem_bus;
  logic [7:0] disk_wdata;
  logic [2:0] drive_select_low;
  int fail_count = 0, tests_run = 0, n_ack, n_id, n_clk = 0, n_dat = 0;
  int seed = 32'hbe829d7a;
  logic [7:0] q[$];
  always #5 clk_sys = ~clk_sys;
  // short motor count keeps the idle wait small
  fdp_transfer #(.MOTOR_CYC(50)) uut (.*);
  fdp_cpu_model cpu (.*);
  // ------------------------------------------------------------
  // stimulus and reference model
  // ------------------------------------------------------------
  always @(negedge clk_sys) begin
    disk_rdata <= 8'($random(seed));
    mem_rdata <= 8'($random(seed));
    dly <= 4'($random(seed));
    read_stream <= (($random(seed) & 31) == 0);
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    tests_run++;
    if (g !== x) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  always @(posedge clk_sys) begin
    if (resetn) begin
      n_clk += sep_clock_pulse;
      n_dat += sep_data_pulse;
      n_id += id_write;
      if (xfer_ack) begin
        n_ack++;
        q.push_back(op == FDP_OP_READ ? disk_rdata : mem_rdata);
        chk(mem_bus.mem_rd, op != FDP_OP_READ);
      end
      if (mem_bus.mem_wr || disk_wstrobe) begin
        e = q.size() ? q.pop_front() : 8'h00;
        chk({mem_bus.mem_wr, disk_wstrobe}, op == FDP_OP_READ ? 2'h2 : 2'h1);
        chk(mem_bus.mem_wr ? mem_bus.data : disk_wdata, e);
      end
      chk($onehot0({drive_select_low, drive_select_fourth}), 1);
    end
  end
  task automatic cmd(input fdp_op_t o, input logic hi, dh,
      input logic [6:0] t, input logic s, input logic [4:0] sc,
      input logic [1:0] d, input logic rf);
    logic r;
    int k;
    @(negedge clk_sys);
    op = o;
    hi_iface = hi;
    disk_hi_fmt = dh;
    sound_port_bit = 1'($random(seed));
    target = '{t, s, sc};
    drive_num = d;
    n_ack = 0;
    n_id = 0;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    r = refused;
    @(negedge clk_sys);
    r = r | refused;
    chk(r, rf);
    if (!rf) begin
      if (o != FDP_OP_FORMAT) begin
        id_seen = '{t, s, sc ^ 5'h1};
        id_valid = 1'b1;
        @(negedge clk_sys);
        chk(xfer_request, 0);
        id_seen = '{t, s, sc};
        @(negedge clk_sys);
        id_valid = 1'b0;
      end
      @(negedge clk_sys);
      chk({drive_select_fourth, drive_select_low},
          {d == 3 && (!hi || sound_port_bit),
           d < 3 ? 3'h1 << d : 3'h0});
      for (k = 0; k < 8000 && busy; k++) @(negedge clk_sys);
      chk(busy, 0);
      chk(n_ack, 256);
      chk(n_id, o == FDP_OP_FORMAT ? 256 : 0);
      chk(motor_stop, 0);
      repeat (60) @(negedge clk_sys);
      chk(motor_stop, 1);
    end
    $display("test done op %0d drive %0d", o, d);
  endtask : cmd
  task summarize();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial begin
    // about five times the expected length of the whole sequence
    #200000;
    fail_count++;
    summarize();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    chk(motor_stop, 1);
    cmd(FDP_OP_READ, 0, 0, 7'h28, 0, 5'h01, 0, 1);
    cmd(FDP_OP_READ, 0, 0, 7'h00, 1, 5'h00, 1, 1);
    cmd(FDP_OP_READ, 0, 0, 7'h00, 0, 5'h11, 2, 1);
    cmd(FDP_OP_WRITE, 1, 0, 7'h00, 0, 5'h01, 3, 1);
    cmd(FDP_OP_READ, 1, 1, 7'h50, 0, 5'h01, 0, 1);
    cmd(FDP_OP_READ, 0, 0, 7'h27, 1, 5'h10, 0, 0);
    cmd(FDP_OP_WRITE, 0, 0, 7'h00, 0, 5'h01, 1, 0);
    cmd(FDP_OP_FORMAT, 0, 0, 7'h05, 1, 5'h03, 2, 0);
    cmd(FDP_OP_READ, 1, 0, 7'h27, 0, 5'h10, 3, 0);
    cmd(FDP_OP_WRITE, 1, 1, 7'h4f, 1, 5'h10, 3, 0);
    chk(n_clk != 0 && n_dat != 0, 1);
    summarize();
  end
endmodule : fdp_transfer_tb
